// File: rtl/spm_serial_port_mode_control.sv
// module: serial port mode control, uart, indicators and query gateway
//
// Behaviour
// - both switches on: console mode, gateway queries refused, query_ready_o held low
// - console link is 9600 baud 8-N-1, terminal must match
// - console mode forces the RS-232 electrical interface
// - console mode uses built-in defaults regardless of stored settings
// - first on, second off: loopback, received characters echoed, dropped while the two-entry buffer is full
// - first off, second on: boot factory image, ignore upgraded image
// - both off: data mode with configured RS-232, RS-422 or RS-485
// - reset button held one second then released resets, indicators blink off
// - power indicator toggles with one-second period once ready
// - receive and transmit indicators lit during respective activity
// - baud rate programmable from 110 up to 230400 bit/s
// - parity none/even/odd/mark/space, 5 to 8 bits, 1/1.5/2 stops
// - default RTU framing, 10 ms character and 100 ms message timeouts
// - inactivity timeout defaults to zero minutes, zero disables it
// - default mode plus save restores every setting to factory values
// - RS-232 uses RTS/CTS only when flow control is set so
// - RS-422 gives rx, tx, rts, cts full duplex, handshake if configured
// - RS-485 half duplex, driver enabled only while transmitting
// - optional exception reply when slave misses message timeout, off by default
// - queued network queries forwarded to serial link one at a time
`timescale 1ns/1ns
`default_nettype none
module spm_serial_port_mode_control #(
    parameter int unsigned HOLD_CYC  = spm_pkg::HOLD_CYC,
    parameter int unsigned BLINK_CYC = spm_pkg::BLINK_CYC,
    parameter int unsigned CHAR_CYC  = spm_pkg::CHAR_TMO_CYC,
    parameter int unsigned MSG_CYC   = spm_pkg::MSG_TMO_CYC,
    parameter int unsigned MIN_CYC   = spm_pkg::CYC_PER_MIN
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    sw_first_i,
    input  wire logic                    sw_second_i,
    input  wire logic                    reset_button_i,
    input  wire logic [spm_pkg::DIV_W-1:0] cfg_baud_div_i,
    input  wire logic [1:0]              cfg_data_bits_i,
    input  wire logic [2:0]              cfg_parity_i,
    input  wire logic [1:0]              cfg_stop_bits_i,
    input  wire logic [1:0]              cfg_if_type_i,
    input  wire logic                    cfg_rtscts_i,
    input  wire logic                    cfg_exc_en_i,
    input  wire logic [7:0]              cfg_inact_min_i,
    input  wire logic                    cfg_default_sel_i,
    input  wire logic                    cfg_save_i,
    input  wire logic                    rx_pin_i,
    input  wire logic                    cts_pin_i,
    input  wire logic [7:0]              query_data_i,
    input  wire logic                    query_valid_i,
    input  wire logic                    query_last_i,
    output logic                         query_ready_o,
    output logic [7:0]                   resp_data_o,
    output logic                         resp_valid_o,
    output logic                         resp_exc_o,
    input  wire logic                    resp_ready_i,
    output logic                         tx_pin_o,
    output logic                         tx_oe_o,
    output logic                         rts_pin_o,
    output logic [1:0]                   mode_o,
    output logic [1:0]                   if_type_o,
    output logic                         factory_boot_o,
    output logic                         console_active_o,
    output logic                         restore_defaults_o,
    output logic                         inact_disconnect_o,
    output logic                         sys_reset_o,
    output logic                         power_ready_indicator_o,
    output logic                         link_run_indicator_o,
    output logic                         receive_activity_indicator_o,
    output logic                         transmit_activity_indicator_o
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic       rx_s;
    logic       cts_s;
    logic       btn_s;
    logic       swa_s;
    logic       swb_s;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 5'h03;
            sync2_reg <= 5'h03;
        end else begin
            sync1_reg <= {sw_second_i, sw_first_i, reset_button_i, cts_pin_i, rx_pin_i};
            sync2_reg <= sync1_reg;
        end
    end
    assign rx_s  = sync2_reg[0];
    assign cts_s = sync2_reg[1];
    assign btn_s = sync2_reg[2];
    assign swa_s = sync2_reg[3];
    assign swb_s = sync2_reg[4];

    // ---------------------------------------------------------------
    // button reset and mode latch
    // ---------------------------------------------------------------
    logic [31:0] hold_reg;
    logic [4:0]  off_reg;
    logic        btn_rst;
    logic        rst;
    logic [2:0]  settle_reg;
    spm_pkg::spm_mode_t mode_reg;
    assign btn_rst = ~btn_s && (hold_reg >= HOLD_CYC);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            hold_reg <= '0;
            off_reg  <= '0;
        end else begin
            hold_reg <= btn_s ? ((hold_reg >= HOLD_CYC) ? hold_reg : hold_reg + 32'h1) : '0;
            if (btn_rst)
                off_reg <= 5'(spm_pkg::RST_OFF_CYC);
            else if (off_reg != '0)
                off_reg <= off_reg - 5'h1;
        end
    end
    assign rst = sys_rst_i || (off_reg != '0);
    assign sys_reset_o = rst;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            settle_reg <= '0;
            mode_reg   <= spm_pkg::SPM_DATA;
        end else if (settle_reg != 3'h7) begin
            settle_reg <= settle_reg + 3'h1;
            mode_reg   <= spm_pkg::spm_mode_t'({swa_s, swb_s});
        end
    end
    logic ready;
    logic console;
    logic loopm;
    assign ready   = settle_reg == 3'h7;
    assign console = ready && mode_reg == spm_pkg::SPM_CONSOLE;
    assign loopm   = ready && mode_reg == spm_pkg::SPM_LOOP;
    assign mode_o           = mode_reg;
    assign console_active_o = console;
    assign factory_boot_o   = ready && mode_reg == spm_pkg::SPM_FACTORY;

    // ---------------------------------------------------------------
    // effective port settings
    // ---------------------------------------------------------------
    logic [spm_pkg::DIV_W-1:0] div;
    logic [1:0] dbits;
    logic [2:0] par;
    logic [1:0] stops;
    logic       fc;
    always_comb begin
        if (console) begin
            div       = spm_pkg::DIV_W'(spm_pkg::CONSOLE_DIV);
            dbits     = spm_pkg::DATA_BITS_8;
            par       = spm_pkg::SPM_PAR_NONE;
            stops     = spm_pkg::STOP_1;
            if_type_o = spm_pkg::SPM_RS232;
            fc        = 1'b0;
        end else begin
            div = (cfg_baud_div_i < spm_pkg::DIV_W'(spm_pkg::DIV_MIN))
                ? spm_pkg::DIV_W'(spm_pkg::DIV_MIN)
                : (cfg_baud_div_i > spm_pkg::DIV_W'(spm_pkg::DIV_MAX))
                ? spm_pkg::DIV_W'(spm_pkg::DIV_MAX) : cfg_baud_div_i;
            dbits     = cfg_data_bits_i;
            par       = cfg_parity_i;
            stops     = cfg_stop_bits_i;
            if_type_o = (cfg_if_type_i > 2'h2) ? spm_pkg::SPM_RS232 : cfg_if_type_i;
            fc        = cfg_rtscts_i && cfg_if_type_i != spm_pkg::SPM_RS485;
        end
    end
    assign restore_defaults_o = cfg_default_sel_i && cfg_save_i && ready;

    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    spm_pkg::spm_st_t rst_reg;
    logic [spm_pkg::DIV_W-1:0] rcnt_reg;
    logic [2:0] rbit_reg;
    logic [7:0] rsh_reg;
    logic       rdone;
    assign rdone = rst_reg == spm_pkg::SPM_STOP && rcnt_reg == '0;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            rst_reg  <= spm_pkg::SPM_IDLE;
            rcnt_reg <= '0;
            rbit_reg <= '0;
            rsh_reg  <= '0;
        end else if (rcnt_reg != '0) begin
            rcnt_reg <= rcnt_reg - 1'b1;
        end else begin
            unique case (rst_reg)
                spm_pkg::SPM_IDLE: if (!rx_s && ready) begin
                    rst_reg  <= spm_pkg::SPM_START;
                    rcnt_reg <= div >> 1;
                end
                spm_pkg::SPM_START: begin
                    rst_reg  <= rx_s ? spm_pkg::SPM_IDLE : spm_pkg::SPM_BITS;
                    rcnt_reg <= div;
                    rbit_reg <= '0;
                end
                spm_pkg::SPM_BITS: begin
                    rsh_reg  <= {rx_s, rsh_reg[7:1]};
                    rcnt_reg <= div;
                    rbit_reg <= rbit_reg + 3'h1;
                    if (rbit_reg == {1'b1, dbits})
                        rst_reg <= (par == spm_pkg::SPM_PAR_NONE) ? spm_pkg::SPM_STOP
                                                                   : spm_pkg::SPM_PAR;
                end
                spm_pkg::SPM_PAR: begin
                    rst_reg  <= spm_pkg::SPM_STOP;
                    rcnt_reg <= div;
                end
                spm_pkg::SPM_STOP: rst_reg <= spm_pkg::SPM_IDLE;
                default: rst_reg <= spm_pkg::SPM_IDLE;
            endcase
        end
    end
    logic [7:0] rx_byte;
    assign rx_byte = rsh_reg >> (2'h3 - dbits);

    // ---------------------------------------------------------------
    // two-entry buffer feeding transmitter
    // ---------------------------------------------------------------
    logic [7:0] buf_reg [2];
    logic [1:0] cnt_reg;
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic       in_valid;
    logic [7:0] in_data;
    logic       in_ready;
    logic       out_take;
    logic       busy_reg;
    logic       tx_q;
    assign in_ready = cnt_reg != 2'h2;
    always_comb begin
        if (loopm) begin
            in_valid = rdone;
            in_data  = rx_byte;
        end else begin
            in_valid = query_valid_i && query_ready_o;
            in_data  = query_data_i;
        end
    end
    assign query_ready_o = in_ready && !loopm && !console && !busy_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            cnt_reg    <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
        end else begin
            if (in_valid && in_ready) begin
                buf_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (out_take)
                rd_ptr_reg <= ~rd_ptr_reg;
            cnt_reg <= cnt_reg + {1'b0, in_valid && in_ready} - {1'b0, out_take};
        end
    end

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    spm_pkg::spm_st_t tst_reg;
    logic [spm_pkg::DIV_W-1:0] tcnt_reg;
    logic [3:0] tbit_reg;
    logic [7:0] tsh_reg;
    logic       tpar_reg;
    logic       cts_ok;
    logic [spm_pkg::DIV_W-1:0] stop_len;
    assign cts_ok   = !fc || !cts_s;
    assign out_take = tst_reg == spm_pkg::SPM_IDLE && cnt_reg != '0 && cts_ok;
    assign stop_len = (stops == spm_pkg::STOP_2) ? div << 1
                    : (stops == spm_pkg::STOP_15) ? div + (div >> 1) : div;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            tst_reg  <= spm_pkg::SPM_IDLE;
            tcnt_reg <= '0;
            tbit_reg <= '0;
            tsh_reg  <= '0;
            tpar_reg <= 1'b0;
            tx_q     <= 1'b1;
        end else if (tcnt_reg != '0) begin
            tcnt_reg <= tcnt_reg - 1'b1;
        end else begin
            unique case (tst_reg)
                spm_pkg::SPM_IDLE: if (out_take) begin
                    tst_reg  <= spm_pkg::SPM_START;
                    tsh_reg  <= buf_reg[rd_ptr_reg];
                    tpar_reg <= 1'b0;
                    tbit_reg <= '0;
                    tx_q     <= 1'b0;
                    tcnt_reg <= div;
                end
                spm_pkg::SPM_START, spm_pkg::SPM_BITS: begin
                    tx_q     <= tsh_reg[0];
                    tpar_reg <= tpar_reg ^ tsh_reg[0];
                    tsh_reg  <= tsh_reg >> 1;
                    tcnt_reg <= div;
                    tbit_reg <= tbit_reg + 4'h1;
                    // parity slot doubles as stop bit when parity is off
                    tst_reg  <= (tbit_reg == {2'h1, dbits}) ? spm_pkg::SPM_PAR
                                                             : spm_pkg::SPM_BITS;
                end
                spm_pkg::SPM_PAR: begin
                    tcnt_reg <= (par == spm_pkg::SPM_PAR_NONE) ? stop_len : div;
                    tst_reg  <= spm_pkg::SPM_STOP;
                    unique case (par)
                        spm_pkg::SPM_PAR_EVEN: tx_q <= tpar_reg;
                        spm_pkg::SPM_PAR_ODD:  tx_q <= ~tpar_reg;
                        spm_pkg::SPM_PAR_SPACE: tx_q <= 1'b0;
                        default:               tx_q <= 1'b1;
                    endcase
                end
                spm_pkg::SPM_STOP: begin
                    tx_q <= 1'b1;
                    if (par != spm_pkg::SPM_PAR_NONE && tbit_reg != 4'hf) begin
                        tcnt_reg <= stop_len;
                        tbit_reg <= 4'hf;
                    end else
                        tst_reg <= spm_pkg::SPM_IDLE;
                end
                default: tst_reg <= spm_pkg::SPM_IDLE;
            endcase
        end
    end
    assign tx_pin_o  = tx_q;
    assign tx_oe_o   = (if_type_o != spm_pkg::SPM_RS485) || tst_reg != spm_pkg::SPM_IDLE;
    assign rts_pin_o = fc ? !in_ready : 1'b0;

    // ---------------------------------------------------------------
    // query sequencing, response and timeouts
    // ---------------------------------------------------------------
    logic [31:0] tmo_reg;
    logic [31:0] gap_reg;
    logic        got_reg;
    logic        resp_v_reg;
    logic        exc_reg;
    logic [7:0]  resp_d_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            busy_reg   <= 1'b0;
            got_reg    <= 1'b0;
            tmo_reg    <= '0;
            gap_reg    <= '0;
            resp_v_reg <= 1'b0;
            exc_reg    <= 1'b0;
            resp_d_reg <= '0;
        end else begin
            if (resp_v_reg && resp_ready_i)
                resp_v_reg <= 1'b0;
            if (query_valid_i && query_ready_o && query_last_i) begin
                busy_reg <= 1'b1;
                got_reg  <= 1'b0;
                tmo_reg  <= '0;
            end else if (busy_reg) begin
                tmo_reg <= tmo_reg + 32'h1;
                gap_reg <= got_reg ? gap_reg + 32'h1 : '0;
                if (rdone && !resp_v_reg) begin
                    resp_v_reg <= 1'b1;
                    resp_d_reg <= rx_byte;
                    exc_reg    <= 1'b0;
                    got_reg    <= 1'b1;
                    gap_reg    <= '0;
                end else if (got_reg && gap_reg >= CHAR_CYC) begin
                    busy_reg <= 1'b0;
                end else if (!got_reg && tmo_reg >= MSG_CYC) begin
                    busy_reg <= 1'b0;
                    if (cfg_exc_en_i && !resp_v_reg) begin
                        resp_v_reg <= 1'b1;
                        exc_reg    <= 1'b1;
                        resp_d_reg <= spm_pkg::EXC_CODE;
                    end
                end
            end
        end
    end
    assign resp_valid_o = resp_v_reg;
    assign resp_data_o  = resp_d_reg;
    assign resp_exc_o   = exc_reg;

    // ---------------------------------------------------------------
    // inactivity and indicators
    // ---------------------------------------------------------------
    logic [31:0] ms_reg;
    logic [7:0]  min_reg;
    logic [31:0] blink_reg;
    logic        pwr_reg;
    logic        act;
    assign act = rdone || out_take || query_valid_i;
    always_ff @(posedge ref_clk_i) begin
        if (rst || act) begin
            ms_reg  <= '0;
            min_reg <= '0;
        end else if (ms_reg >= MIN_CYC - 1) begin
            ms_reg  <= '0;
            min_reg <= (min_reg == 8'hff) ? min_reg : min_reg + 8'h1;
        end else
            ms_reg <= ms_reg + 32'h1;
    end
    assign inact_disconnect_o = cfg_inact_min_i != '0 && min_reg >= cfg_inact_min_i;
    always_ff @(posedge ref_clk_i) begin
        if (rst || !ready) begin
            blink_reg <= '0;
            pwr_reg   <= 1'b0;
        end else if (blink_reg >= BLINK_CYC - 1) begin
            blink_reg <= '0;
            pwr_reg   <= ~pwr_reg;
        end else
            blink_reg <= blink_reg + 32'h1;
    end
    assign power_ready_indicator_o       = pwr_reg;
    assign link_run_indicator_o          = ready;
    assign receive_activity_indicator_o  = rst_reg != spm_pkg::SPM_IDLE;
    assign transmit_activity_indicator_o = tst_reg != spm_pkg::SPM_IDLE;
endmodule
`default_nettype wire

// File: rtl/spm_pkg.sv
// package: constants and types for the serial port mode control block
package spm_pkg;
    localparam int unsigned CLK_HZ            = 50000000;
    localparam int unsigned CONSOLE_BAUD      = 9600;
    localparam int unsigned BAUD_MIN          = 110;
    localparam int unsigned BAUD_MAX         = 230400;
    localparam int unsigned CONSOLE_DIV       = CLK_HZ / CONSOLE_BAUD;
    localparam int unsigned DIV_MIN           = CLK_HZ / BAUD_MAX;
    localparam int unsigned DIV_MAX           = CLK_HZ / BAUD_MIN;
    localparam int unsigned DIV_W             = 20;
    localparam int unsigned HOLD_MS           = 1000;
    localparam int unsigned BLINK_MS          = 500;
    localparam int unsigned CHAR_TMO_MS       = 10;
    localparam int unsigned MSG_TMO_MS        = 100;
    localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
    localparam int unsigned HOLD_CYC          = HOLD_MS * CYC_PER_MS;
    localparam int unsigned BLINK_CYC         = BLINK_MS * CYC_PER_MS;
    localparam int unsigned CHAR_TMO_CYC      = CHAR_TMO_MS * CYC_PER_MS;
    localparam int unsigned MSG_TMO_CYC       = MSG_TMO_MS * CYC_PER_MS;
    localparam int unsigned INACT_DEF_MIN     = 0;
    localparam int unsigned CYC_PER_MIN       = CYC_PER_MS * 60000;
    localparam int unsigned RST_OFF_CYC       = 16;
    localparam logic [1:0]  DATA_BITS_8       = 2'h3;
    localparam logic [1:0]  STOP_1            = 2'h0;
    localparam logic [1:0]  STOP_15           = 2'h1;
    localparam logic [1:0]  STOP_2            = 2'h2;
    localparam logic [7:0]  EXC_CODE          = 8'h0b;

    typedef enum logic [1:0] {
        SPM_DATA     = 2'h0,
        SPM_FACTORY  = 2'h1,
        SPM_LOOP     = 2'h2,
        SPM_CONSOLE  = 2'h3
    } spm_mode_t;

    typedef enum logic [1:0] {
        SPM_RS232 = 2'h0,
        SPM_RS422 = 2'h1,
        SPM_RS485 = 2'h2
    } spm_if_t;

    typedef enum logic [2:0] {
        SPM_PAR_NONE  = 3'h0,
        SPM_PAR_EVEN  = 3'h1,
        SPM_PAR_ODD   = 3'h2,
        SPM_PAR_MARK  = 3'h3,
        SPM_PAR_SPACE = 3'h4
    } spm_par_t;

    typedef enum logic [2:0] {
        SPM_IDLE  = 3'h0,
        SPM_START = 3'h1,
        SPM_BITS  = 3'h3,
        SPM_PAR   = 3'h2,
        SPM_STOP  = 3'h6
    } spm_st_t;
endpackage

// File: test/spm_serial_port_mode_control_assertions.sv
// checker: assertions on the mode control ports
`timescale 1ns/1ns
`default_nettype none
module spm_chk (
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       cfg_rtscts_i,
    input wire logic       tx_oe_o,
    input wire logic       rts_pin_o,
    input wire logic [1:0] mode_o,
    input wire logic [1:0] if_type_o,
    input wire logic       factory_boot_o,
    input wire logic       console_active_o,
    input wire logic       link_run_indicator_o,
    input wire logic       transmit_activity_indicator_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_con_mode: assert property (console_active_o |-> mode_o == 2'h3) else $error("mode");
    a_con_if: assert property (console_active_o |-> if_type_o == 2'h0) else $error("if");
    a_con_rts: assert property (console_active_o |-> !rts_pin_o) else $error("rts");
    a_fac_mode: assert property (factory_boot_o |-> mode_o == 2'h1) else $error("boot");
    a_mode_held: assert property (link_run_indicator_o && $past(link_run_indicator_o) |->
        $stable(mode_o)) else $error("mode moved");
    a_oe_idle: assert property (if_type_o == 2'h2 && !transmit_activity_indicator_o |->
        !tx_oe_o) else $error("oe idle");
    a_oe_busy: assert property (if_type_o == 2'h2 && transmit_activity_indicator_o |->
        tx_oe_o) else $error("oe busy");
    a_rts_off: assert property (!cfg_rtscts_i |-> !rts_pin_o) else $error("rts on");
endmodule
bind spm_serial_port_mode_control spm_chk spm_chk_i (.ref_clk_i, .sys_rst_i, .cfg_rtscts_i,
    .tx_oe_o, .rts_pin_o, .mode_o, .if_type_o, .factory_boot_o, .console_active_o,
    .link_run_indicator_o, .transmit_activity_indicator_o);
`default_nettype wire

// File: test/spm_term.sv
// partner: serial terminal, 8-N-1 frames lsb first
`timescale 1ns/1ns
`default_nettype none
module spm_term #(parameter int BIT = 218) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic [7:0] got;
    logic [9:0] f;
    int         n_got = 0;
    initial line_o = 1'h1;
    task send(input logic [7:0] b);
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    always begin
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            got[i] = line_i;
        end
        n_got++;
    end
endmodule
`default_nettype wire

// File: test/spm_serial_port_mode_control_tb.sv
// testbench: mode switches, loopback echo, indicators, reset button
`timescale 1ns/1ns
`default_nettype none
module spm_serial_port_mode_control_tb;
    logic       clk = 1'h0, rst = 1'h1, sw1 = 1'h0, sw2 = 1'h0, btn = 1'h0, dsel = 1'h0;
    logic       save = 1'h0, p, tx, oe, fb, con, rd, power_ready_indicator, link, txa;
    logic [1:0] mode, ift;
    wire logic  rx;
    logic [19:0] div = 20'h000d9;
    logic [7:0] qd = 8'h00, rdat;
    logic [1:0] ifs = 2'h2;
    logic       fc = 1'h0, cts = 1'h0, qv = 1'h0, ql = 1'h0, rr = 1'h1, qr, rv, rex, rts, rxa;
    int         compares = 0, miscompares = 0, n, t;
    always #10 clk = ~clk;
    spm_serial_port_mode_control #(.HOLD_CYC(200), .BLINK_CYC(50), .MSG_CYC(3000))
        spm_serial_port_mode_control_i (.ref_clk_i(clk), .sys_rst_i(rst), .sw_first_i(sw1),
        .sw_second_i(sw2), .reset_button_i(btn), .cfg_baud_div_i(div),
        .cfg_data_bits_i(2'h3), .cfg_parity_i(3'h0), .cfg_stop_bits_i(2'h0),
        .cfg_if_type_i(ifs), .cfg_rtscts_i(fc), .cfg_exc_en_i(1'h1), .cfg_inact_min_i(8'h00),
        .cfg_default_sel_i(dsel), .cfg_save_i(save), .rx_pin_i(rx), .cts_pin_i(cts),
        .query_data_i(qd), .query_valid_i(qv), .query_last_i(ql), .query_ready_o(qr),
        .resp_data_o(rdat), .resp_valid_o(rv), .resp_exc_o(rex), .resp_ready_i(rr),
        .tx_pin_o(tx), .tx_oe_o(oe), .rts_pin_o(rts), .mode_o(mode), .if_type_o(ift),
        .factory_boot_o(fb), .console_active_o(con), .restore_defaults_o(rd),
        .inact_disconnect_o(), .sys_reset_o(), .power_ready_indicator_o(power_ready_indicator),
        .link_run_indicator_o(link), .receive_activity_indicator_o(rxa),
        .transmit_activity_indicator_o(txa));
    spm_term spm_term_i (.clk_i(clk), .line_i(oe ? tx : 1'h1), .line_o(rx));
    task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        final_report;
    end
    initial begin
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            {sw1, sw2} <= 2'(m);
            rst <= 1'h1;
            repeat (16) @(posedge clk);
            rst <= 1'h0;
            repeat (12) @(negedge clk);
            chk("mode", mode, 8'(m));
            chk("console", con, 8'(m == 3));
            chk("factory", fb, 8'(m == 1));
            chk("if_type", ift, (m == 3) ? 8'h00 : 8'h02);
            @(posedge clk);
            {sw1, sw2} <= ~2'(m);
            dsel <= m[0];
            save <= m[1];
            repeat (20) @(negedge clk);
            chk("held", mode, 8'(m));
            chk("restore", rd, 8'(m == 3));
            if (m == 2) begin
                repeat (2500) @(posedge clk);
                n = spm_term_i.n_got;
                fork spm_term_i.send(8'ha5); join_none
                for (t = 0; t < 3000 && rxa !== 1'h1; t++) @(negedge clk);
                chk("receive_activity_indicator", rxa, 8'h01);
                for (t = 0; t < 3000 && txa !== 1'h1; t++) @(negedge clk);
                chk("transmit_activity_indicator", txa, 8'h01);
                for (t = 0; t < 3000 && spm_term_i.n_got == n; t++) @(posedge clk);
                chk("echo", spm_term_i.got, 8'ha5);
            end
        end
        p = power_ready_indicator;
        for (t = 0; t < 200 && power_ready_indicator === p; t++) @(negedge clk);
        p = power_ready_indicator;
        for (t = 0; t < 200 && power_ready_indicator === p; t++) @(negedge clk);
        chk("blink", 8'(t), 8'h32);
        @(posedge clk);
        btn <= 1'h1;
        repeat (250) @(posedge clk);
        btn <= 1'h0;
        repeat (8) @(negedge clk);
        chk("link_off", link, 8'h00);
        repeat (60) @(negedge clk);
        chk("link_on", link, 8'h01);
        // data mode query, rs-485 ignores flow control, slave stays silent
        n = spm_term_i.n_got;
        @(posedge clk);
        {qv, ql, fc, cts, rr} <= 5'h1e;
        qd <= 8'h5a;
        @(posedge clk);
        while (qr !== 1'h1) @(posedge clk);
        {qv, ql} <= 2'h0;
        repeat (20) @(negedge clk);
        chk("q_busy", qr, 8'h00);
        chk("rts", rts, 8'h00);
        for (t = 0; t < 3000 && spm_term_i.n_got == n; t++) @(posedge clk);
        chk("query", spm_term_i.got, 8'h5a);
        for (t = 0; t < 3000 && rv !== 1'h1; t++) @(negedge clk);
        chk("exc", rex, 8'h01);
        chk("exc_code", rdat, spm_pkg::EXC_CODE);
        chk("q_free", qr, 8'h01);
        repeat (3) @(negedge clk);
        chk("stands", rv, 8'h01);
        @(posedge clk);
        rr <= 1'h1;
        repeat (2) @(negedge clk);
        chk("taken", rv, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
